// file: hdl/mof_map.vh
// Register map, field layout, reset values and timing counts for the monitor block
`ifndef MOF_MAP_VH
`define MOF_MAP_VH

// Register offsets (byte addresses)
`define MOF_ADDR_CTRL 8'h00
`define MOF_ADDR_OLVL 8'h04
`define MOF_ADDR_ACC 8'h08
`define MOF_ADDR_DEC 8'h0c
`define MOF_ADDR_PDEV 8'h10
`define MOF_ADDR_DBG 8'h14
`define MOF_ADDR_STAT 8'h18
`define MOF_ADDR_IRQ 8'h1c
`define MOF_ADDR_MASK 8'h20

// Control field positions
`define MOF_CTRL_SEL_LO 0
`define MOF_CTRL_SEL_HI 1
`define MOF_CTRL_OUTOPT_LO 4
`define MOF_CTRL_OUTOPT_HI 6

// Monitor selection codes
`define MOF_SEL_FREQ 2'h0
`define MOF_SEL_CURR 2'h1
`define MOF_SEL_SQR 2'h2

// Logic output option codes
`define MOF_OPT_RUN 3'h0
`define MOF_OPT_FA1 3'h1
`define MOF_OPT_FA2 3'h2
`define MOF_OPT_OL 3'h3
`define MOF_OPT_OD 3'h4

// Reset values and deviation limit maximum
`define MOF_RST_CTRL 8'h10
`define MOF_RST_ACC 16'h0000
`define MOF_RST_DEC 16'h0000
`define MOF_RST_PDEV 10'h01e
`define MOF_RST_DBG 8'h00
`define MOF_PDEV_MAX 10'h3e8

// Status / interrupt bit positions
`define MOF_IRQ_OL 0
`define MOF_IRQ_FA1 1
`define MOF_IRQ_FA2 2
`define MOF_IRQ_OD 3

// PWM carrier: 10.24 us period at 100 MHz, duty in 1/1024 steps
`define MOF_CARRIER_NS 10240
`define MOF_CLK_NS 10
`define MOF_CARRIER_CYC (`MOF_CARRIER_NS / `MOF_CLK_NS)

`endif

// file: hdl/mof_monitor.v
// Monitor waveform generator and threshold flag logic
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
// How it works
// - Select 00: PWM duty follows output frequency
// - Select 01: duty follows current, full at 2x
// - Select 02: 50% square at output frequency
// - Overload flag when current exceeds overload level
// - Overload flag is informative, no trip/limit
// - Overload level defaults to rated current
// - Acceleration threshold turns over-speed flag on
// - Deceleration threshold turns over-speed flag off
// - PID error is absolute setpoint minus process
// - Option 04 flags error above deviation limit
// - Deviation limit 0-100% in 0.1% steps, default 3
// - Only monitor codes 00, 01, 02 valid
// - Constant-speed flag only at set frequency
// - Over-speed flag at or above set frequency
// - Option 03 routes overload flag to terminal
`include "mof_map.vh"

module mof_monitor #(
   parameter [15:0] RATED_CURRENT = 16'h0100,
   parameter [15:0] MAX_FREQ = 16'h0258
) (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Register port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   // Drive state, frequency in 0.1 Hz, current in rated units
   input wire running,
   input wire [15:0] out_freq,
   input wire [15:0] set_freq,
   input wire [15:0] motor_current,
   input wire [9:0] pid_setpoint,
   input wire [9:0] pid_process_variable,
   // Square-wave timing: clock cycles per output cycle half
   input wire [31:0] sqr_half_cycles,
   // Outputs
   output reg monitor_output_terminal,
   output reg logic_output,
   output reg overload_warning_flag,
   output reg constant_speed_arrival_flag,
   output reg over_speed_arrival_flag,
   output reg pid_deviation_flag,
   output wire irq
);

   localparam integer CARRIER_CYC = `MOF_CARRIER_CYC;
   localparam [10:0] CARRIER = CARRIER_CYC[10:0];

   reg [7:0] ctrl_r;
   reg [15:0] olvl_r;
   reg [15:0] acc_r;
   reg [15:0] dec_r;
   reg [9:0] pdev_r;
   reg [7:0] dbg_r;
   reg [3:0] stat_r;
   reg [3:0] mask_r;
   reg [15:0] prev_freq_r;
   reg [10:0] pwm_cnt_r;
   reg [10:0] duty_r;
   reg [31:0] sqr_cnt_r;
   reg sqr_r;
   reg [3:0] flags_d_r;

   wire [1:0] sel = ctrl_r[`MOF_CTRL_SEL_HI:`MOF_CTRL_SEL_LO];
   wire [2:0] outopt = ctrl_r[`MOF_CTRL_OUTOPT_HI:`MOF_CTRL_OUTOPT_LO];

   // Scale a value to 0..1024 duty, clipped at full scale
   function [10:0] scale_duty;
      input [15:0] val;
      input [15:0] full;
      reg [26:0] prod;
      reg [26:0] quot;
      begin
         prod = {1'b0, val, 10'h000};
         quot = 27'h0;
         if (full == 16'h0000 || val >= full) begin
            scale_duty = 11'h400;
         end else begin
            // Quotient is below 1024 here, upper bits are zero
            quot = prod / {11'h000, full};
            scale_duty = quot[10:0];
         end
      end
   endfunction

   // PID error magnitude, sign dropped
   wire [9:0] pid_err = (pid_setpoint >= pid_process_variable) ?
      pid_setpoint - pid_process_variable :
      pid_process_variable - pid_setpoint;

   wire accel = out_freq > prev_freq_r;
   wire decel = out_freq < prev_freq_r;
   wire cfg_wr = wr && !running;

   // Arrival thresholds below set frequency, floored at zero
   wire [15:0] acc_lvl = (acc_r > set_freq) ? 16'h0000 :
      set_freq - acc_r;
   wire [15:0] dec_lvl = (dec_r > set_freq) ? 16'h0000 :
      set_freq - dec_r;

   // Register writes; parameters frozen during run, interrupt mask still writable
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= `MOF_RST_CTRL;
         olvl_r <= 16'h0000;
         acc_r <= `MOF_RST_ACC;
         dec_r <= `MOF_RST_DEC;
         pdev_r <= `MOF_RST_PDEV;
         dbg_r <= `MOF_RST_DBG;
         mask_r <= 4'h0;
      end else begin
         if (cfg_wr && addr == `MOF_ADDR_CTRL) begin
            // Codes above 02 are refused, keep old selection
            if (wdata[1:0] != 2'h3) begin
               ctrl_r[1:0] <= wdata[1:0];
            end
            ctrl_r[6:4] <= wdata[6:4];
         end
         if (cfg_wr && addr == `MOF_ADDR_OLVL) begin
            // Above twice rated current, set level to all ones
            if (wdata[16:0] > {RATED_CURRENT, 1'b0}) begin
               olvl_r <= 16'hffff;
            end else begin
               olvl_r <= wdata[15:0];
            end
         end
         if (cfg_wr && addr == `MOF_ADDR_ACC) begin
            acc_r <= wdata[15:0];
         end
         if (cfg_wr && addr == `MOF_ADDR_DEC) begin
            dec_r <= wdata[15:0];
         end
         if (cfg_wr && addr == `MOF_ADDR_PDEV &&
             wdata[9:0] <= `MOF_PDEV_MAX) begin
            pdev_r <= wdata[9:0];
         end
         if (cfg_wr && addr == `MOF_ADDR_DBG) begin
            dbg_r <= wdata[7:0];
         end
         if (wr && addr == `MOF_ADDR_MASK) begin
            mask_r <= wdata[3:0];
         end
      end
   end

   // Overload level follows rated current until first write
   reg olvl_set_r;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         olvl_set_r <= 1'b0;
      end else if (cfg_wr && addr == `MOF_ADDR_OLVL) begin
         olvl_set_r <= 1'b1;
      end
   end
   wire [15:0] olvl_eff = olvl_set_r ? olvl_r : RATED_CURRENT;

   // Threshold flags; overload never touches drive current
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prev_freq_r <= 16'h0000;
         overload_warning_flag <= 1'b0;
         constant_speed_arrival_flag <= 1'b0;
         over_speed_arrival_flag <= 1'b0;
         pid_deviation_flag <= 1'b0;
      end else begin
         prev_freq_r <= out_freq;
         overload_warning_flag <= motor_current > olvl_eff;
         pid_deviation_flag <= pid_err > pdev_r;
         if (!running || out_freq == 16'h0000) begin
            constant_speed_arrival_flag <= 1'b0;
            over_speed_arrival_flag <= 1'b0;
         end else if (accel) begin
            // Ramping up: over-speed arrival asserts from accel threshold
            constant_speed_arrival_flag <= 1'b0;
            if (out_freq >= acc_lvl) begin
               over_speed_arrival_flag <= 1'b1;
            end else begin
               over_speed_arrival_flag <= 1'b0;
            end
         end else if (decel) begin
            // Ramping down: hold until below decel threshold
            constant_speed_arrival_flag <= 1'b0;
            if (out_freq < dec_lvl) begin
               over_speed_arrival_flag <= 1'b0;
            end else if (out_freq >= set_freq) begin
               // Set frequency lowered mid-ramp: still at or above it
               over_speed_arrival_flag <= 1'b1;
            end
         end else begin
            constant_speed_arrival_flag <= out_freq == set_freq;
            over_speed_arrival_flag <= out_freq >= set_freq;
         end
      end
   end

   // Selected logic output terminal
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         logic_output <= 1'b0;
      end else begin
         case (outopt)
            `MOF_OPT_RUN: logic_output <= running;
            `MOF_OPT_FA1: logic_output <= constant_speed_arrival_flag;
            `MOF_OPT_FA2: logic_output <= over_speed_arrival_flag;
            `MOF_OPT_OL: logic_output <= overload_warning_flag;
            `MOF_OPT_OD: logic_output <= pid_deviation_flag;
            default: logic_output <= 1'b0;
         endcase
      end
   end

   // PWM carrier; duty latched only at boundary to avoid glitches
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pwm_cnt_r <= 11'h000;
         duty_r <= 11'h000;
      end else if (pwm_cnt_r == CARRIER - 11'h001) begin
         pwm_cnt_r <= 11'h000;
         if (sel == `MOF_SEL_CURR) begin
            duty_r <= scale_duty(motor_current,
               {RATED_CURRENT[14:0], 1'b0});
         end else begin
            duty_r <= scale_duty(out_freq, MAX_FREQ);
         end
      end else begin
         pwm_cnt_r <= pwm_cnt_r + 11'h001;
      end
   end

   // Square wave: toggles every half period, stops at zero
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sqr_cnt_r <= 32'h00000000;
         sqr_r <= 1'b0;
      end else if (!running || out_freq == 16'h0000) begin
         sqr_cnt_r <= 32'h00000000;
         sqr_r <= 1'b0;
      end else if (sqr_cnt_r + 32'h00000001 >= sqr_half_cycles) begin
         sqr_cnt_r <= 32'h00000000;
         sqr_r <= ~sqr_r;
      end else begin
         sqr_cnt_r <= sqr_cnt_r + 32'h00000001;
      end
   end

   // Monitor terminal mux
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         monitor_output_terminal <= 1'b0;
      end else begin
         case (sel)
            `MOF_SEL_FREQ: monitor_output_terminal <= pwm_cnt_r < duty_r;
            `MOF_SEL_CURR: monitor_output_terminal <= pwm_cnt_r < duty_r;
            `MOF_SEL_SQR: monitor_output_terminal <= sqr_r;
            default: monitor_output_terminal <= 1'b0;
         endcase
      end
   end

   // Sticky status on flag rising edges; set beats clear
   wire [3:0] flags_now = {pid_deviation_flag, over_speed_arrival_flag,
      constant_speed_arrival_flag, overload_warning_flag};
   wire [3:0] rise = flags_now & ~flags_d_r;
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flags_d_r <= 4'h0;
         stat_r <= 4'h0;
      end else begin
         flags_d_r <= flags_now;
         if (wr && addr == `MOF_ADDR_IRQ) begin
            stat_r <= (stat_r & ~wdata[3:0]) | rise;
         end else begin
            stat_r <= stat_r | rise;
         end
      end
   end
   assign irq = |(stat_r & mask_r);

   // Read port, data one cycle after strobe
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata <= 32'h00000000;
      end else if (rd) begin
         case (addr)
            `MOF_ADDR_CTRL: rdata <= {24'h000000, ctrl_r};
            `MOF_ADDR_OLVL: rdata <= {16'h0000, olvl_eff};
            `MOF_ADDR_ACC: rdata <= {16'h0000, acc_r};
            `MOF_ADDR_DEC: rdata <= {16'h0000, dec_r};
            `MOF_ADDR_PDEV: rdata <= {22'h000000, pdev_r};
            `MOF_ADDR_DBG: rdata <= {24'h000000, dbg_r};
            `MOF_ADDR_STAT: rdata <= {27'h0000000, running, flags_now};
            `MOF_ADDR_IRQ: rdata <= {28'h0000000, stat_r};
            `MOF_ADDR_MASK: rdata <= {28'h0000000, mask_r};
            default: rdata <= 32'h00000000;
         endcase
      end else begin
         rdata <= 32'h00000000;
      end
   end

endmodule

// file: dv/mof_meter.sv
// Meter model timing the monitor terminal waveform
`timescale 1ns/1ps
module mof_meter (
   // Clock and reset
   input wire clock,
   input wire rstn,
   // Monitored waveform
   input wire mon,
   // Last high time and period, in clock cycles
   output reg [15:0] hi_len,
   output reg [15:0] per_len
);
   reg mon_r;
   reg [15:0] hi_r;
   reg [15:0] cnt_r;
   // Restart both counts at each rising edge of the waveform
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mon_r <= 1'b0;
         hi_r <= 16'h0;
         cnt_r <= 16'h0;
         hi_len <= 16'h0;
         per_len <= 16'h0;
      end else begin
         mon_r <= mon;
         if (mon && !mon_r) begin
            hi_len <= hi_r;
            per_len <= cnt_r;
            hi_r <= 16'h1;
            cnt_r <= 16'h1;
         end else begin
            hi_r <= hi_r + {15'h0, mon};
            cnt_r <= cnt_r + 16'h1;
         end
      end
   end
endmodule

// file: dv/mof_monitor_asserts.sv
// Assertion checker for the monitor and flag block
`timescale 1ns/1ps
`include "mof_map.vh"
module mof_monitor_asserts #(
   parameter [15:0] RATED_CURRENT = 16'h0100
) (
   // Clock, reset and register writes
   input wire clock,
   input wire rstn,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   // Drive state
   input wire running,
   input wire [15:0] out_freq,
   input wire [15:0] set_freq,
   input wire [15:0] motor_current,
   input wire [9:0] pid_setpoint,
   input wire [9:0] pid_process_variable,
   // Flags
   input wire logic_output,
   input wire overload_warning_flag,
   input wire constant_speed_arrival_flag,
   input wire over_speed_arrival_flag,
   input wire pid_deviation_flag
);
   reg up_r;
   reg [15:0] olvl_r;
   reg [9:0] pdev_r;
   reg [2:0] opt_r;
   reg sel_flag;
   wire cfg = wr && !running;
   wire [9:0] err = (pid_setpoint > pid_process_variable) ?
      pid_setpoint - pid_process_variable :
      pid_process_variable - pid_setpoint;
   // Shadow settings; writes in run mode are dropped as in the block
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         up_r <= 1'b0;
         olvl_r <= RATED_CURRENT;
         pdev_r <= `MOF_RST_PDEV;
         opt_r <= 3'h1;
      end else begin
         up_r <= 1'b1;
         if (cfg && addr == `MOF_ADDR_OLVL)
            olvl_r <= (wdata[16:0] > {RATED_CURRENT, 1'b0}) ?
               16'hffff : wdata[15:0];
         if (cfg && addr == `MOF_ADDR_PDEV && wdata[9:0] <= `MOF_PDEV_MAX)
            pdev_r <= wdata[9:0];
         if (cfg && addr == `MOF_ADDR_CTRL)
            opt_r <= wdata[6:4];
      end
   end
   // Flag routed by the output option
   always @* begin
      case (opt_r)
         3'h0: sel_flag = running;
         3'h1: sel_flag = constant_speed_arrival_flag;
         3'h2: sel_flag = over_speed_arrival_flag;
         3'h3: sel_flag = overload_warning_flag;
         3'h4: sel_flag = pid_deviation_flag;
         default: sel_flag = 1'b0;
      endcase
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_steady;
      up_r && running && out_freq != 16'h0 && $stable(out_freq);
   endsequence
   AST_OL_LEVEL: assert property (
      up_r |-> overload_warning_flag == $past(motor_current > olvl_r))
      else $error("overload flag wrong");
   AST_PID_DEV: assert property (
      up_r |-> pid_deviation_flag == $past(err > pdev_r))
      else $error("deviation flag wrong");
   AST_FA1_RAMP: assert property (
      up_r && out_freq != $past(out_freq) |=> !constant_speed_arrival_flag)
      else $error("constant speed flag on in ramp");
   AST_FA1_STEADY: assert property (
      s_steady ##0 out_freq == set_freq |=> constant_speed_arrival_flag)
      else $error("constant speed flag off");
   AST_FA2_STEADY: assert property (
      s_steady ##0 out_freq >= set_freq |=> over_speed_arrival_flag)
      else $error("over speed flag off");
   AST_FA2_ACCEL: assert property (
      up_r && running && out_freq > $past(out_freq) && out_freq >= set_freq
      |=> over_speed_arrival_flag) else $error("over speed off in ramp");
   AST_STOPPED: assert property (
      !running |=> !constant_speed_arrival_flag && !over_speed_arrival_flag)
      else $error("arrival flag on while stopped");
   AST_FA2_AT_SET: assert property (
      up_r && running && out_freq != 16'h0 && out_freq >= set_freq
      |=> over_speed_arrival_flag) else $error("over speed off above set");
   AST_LOGIC_SEL: assert property (
      up_r |-> logic_output == $past(sel_flag))
      else $error("logic output wrong");
endmodule
bind mof_monitor mof_monitor_asserts #(.RATED_CURRENT(RATED_CURRENT)) u_chk (
   .clock, .rstn, .addr, .wdata, .wr, .running, .out_freq, .set_freq,
   .motor_current, .pid_setpoint, .pid_process_variable, .logic_output,
   .overload_warning_flag, .constant_speed_arrival_flag,
   .over_speed_arrival_flag, .pid_deviation_flag);

// file: dv/mof_monitor_bench.sv
// Self-checking bench for the monitor and flag block
`timescale 1ns/1ps
`include "mof_map.vh"
module mof_monitor_bench;
   reg clock, rstn, wr, rd, running;
   reg [7:0] addr;
   reg [31:0] wdata, sqr_half_cycles;
   reg [15:0] out_freq, set_freq, motor_current;
   reg [9:0] pid_setpoint, pid_process_variable;
   wire [31:0] rdata;
   wire mon, lout, ol, fa1, fa2, od, irq;
   wire [15:0] hi_len, per_len;
   integer num_errors, cmp_count, cyc, i;
   mof_monitor u_dut (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata,
      .running, .out_freq, .set_freq, .motor_current, .pid_setpoint,
      .pid_process_variable, .sqr_half_cycles,
      .monitor_output_terminal(mon), .logic_output(lout),
      .overload_warning_flag(ol), .constant_speed_arrival_flag(fa1),
      .over_speed_arrival_flag(fa2), .pid_deviation_flag(od), .irq(irq));
   mof_meter u_meter (.clock, .rstn, .mon, .hi_len, .per_len);
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clock);
   endtask
   task wreg(input [7:0] a, input [31:0] d);
      begin
         @(posedge clock);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clock);
         wr <= 1'b0;
      end
   endtask
   // Read data stands only in the cycle after the strobe
   task rchk(input [7:0] a, input [31:0] exp);
      begin
         @(posedge clock);
         addr <= a;
         rd <= 1'b1;
         @(posedge clock);
         rd <= 1'b0;
         #1 chk(rdata, exp);
      end
   endtask
   // Apply an error pair, expect flag and routed output
   task pchk(input [9:0] sp, input [9:0] pv, input exp);
      begin
         tick(1);
         pid_setpoint <= sp;
         pid_process_variable <= pv;
         tick(3);
         #1 chk(od, exp);
         chk(lout, exp);
      end
   endtask
   // One edge after a frequency step shows the ramp decision
   task fchk(input [15:0] f, input [1:0] exp);
      begin
         tick(1);
         out_freq <= f;
         tick(1);
         #1 chk({fa2, fa1}, exp);
      end
   endtask
   task summarize;
      begin
         if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Cycle ceiling; the sequence needs about 9100 cycles
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         num_errors = num_errors + 1;
         summarize;
      end
   end
   initial begin
      {num_errors, cmp_count, cyc} = 0;
      {rstn, wr, rd, running, addr, wdata, out_freq, motor_current} = 0;
      {pid_setpoint, pid_process_variable} = 0;
      set_freq = 16'h0100;
      sqr_half_cycles = 32'd20;
      tick(4);
      rstn <= 1'b1;
      // Reset values, unmapped 0x24 reads zero; debug left at zero
      for (i = 0; i < 10; i = i + 1)
         rchk(i * 4, i == 0 ? 32'h10 : i == 1 ? 32'h100 :
            i == 4 ? 32'h1e : 0);
      wreg(`MOF_ADDR_PDEV, 32'd1001);
      rchk(`MOF_ADDR_PDEV, 32'h1e);
      wreg(`MOF_ADDR_PDEV, 32'd50);
      wreg(`MOF_ADDR_OLVL, 32'hc0);
      wreg(`MOF_ADDR_CTRL, 32'h30);
      wreg(`MOF_ADDR_MASK, 32'h1);
      wreg(`MOF_ADDR_ACC, 32'h10);
      wreg(`MOF_ADDR_DEC, 32'h20);
      running <= 1'b1;
      wreg(`MOF_ADDR_OLVL, 32'h50);
      rchk(`MOF_ADDR_OLVL, 32'hc0);
      tick(1);
      motor_current <= 16'hc1;
      tick(3);
      #1 chk({ol, lout, irq}, 3'h7);
      wreg(`MOF_ADDR_IRQ, 32'h1);
      #1 chk(irq, 0);
      tick(1);
      motor_current <= 16'hc0;
      tick(3);
      #1 chk({ol, lout}, 0);
      tick(1);
      running <= 1'b0;
      wreg(`MOF_ADDR_CTRL, 32'h40);
      running <= 1'b1;
      pchk(10'd100, 10'd150, 1'b0);
      pchk(10'd100, 10'd151, 1'b1);
      pchk(10'd151, 10'd100, 1'b1);
      fchk(16'he0, 2'b00);
      fchk(16'hf0, 2'b10);
      fchk(16'h100, 2'b10);
      fchk(16'h100, 2'b11);
      fchk(16'he8, 2'b10);
      fchk(16'hd8, 2'b00);
      fchk(16'hd8, 2'b00);
      // Set frequency lowered under a falling output
      tick(1);
      set_freq <= 16'h00c0;
      out_freq <= 16'h00d0;
      tick(1);
      #1 chk({fa2, fa1}, 2'b10);
      // Half of full scale frequency, a quarter of full scale current
      out_freq <= 16'h12c;
      motor_current <= 16'h80;
      for (i = 0; i < 3; i = i + 1) begin
         tick(1);
         running <= 1'b0;
         wreg(`MOF_ADDR_CTRL, i);
         running <= 1'b1;
         tick(3000);
         #1 chk(per_len, i == 2 ? 40 : 1024);
         chk(hi_len, i == 0 ? 512 : i == 1 ? 256 : 20);
      end
      tick(1);
      running <= 1'b0;
      wreg(`MOF_ADDR_CTRL, 32'h13);
      rchk(`MOF_ADDR_CTRL, 32'h12);
      summarize;
   end
endmodule
